/* hdl/bf_pkg.sv */
// shared constants and carrier types for the bidirectional queue flag logic
`default_nettype none

package bf_pkg;

    localparam int DATA_W = 36;
    localparam int DEPTH_DEF = 256;
    localparam int OFS_W = 10;
    localparam int Q_ONE = 0;
    localparam int Q_TWO = 1;
    localparam logic MAIL_EMPTY = 1'b1;

    typedef struct packed {
        logic port_select_n;
        logic port_direction;
        logic port_enable;
        logic port_mail_select;
    } bf_port_ctrl_t;

    typedef struct packed {
        logic [OFS_W-1:0] q1_empty_offset;
        logic [OFS_W-1:0] q1_full_offset;
        logic [OFS_W-1:0] q2_empty_offset;
        logic [OFS_W-1:0] q2_full_offset;
    } bf_offsets_t;

    typedef enum logic [1:0] {
        OUT_EMPTY = 2'b01,
        OUT_HELD  = 2'b10
    } bf_out_state_t;

endpackage : bf_pkg

`default_nettype wire

/* hdl/bf_flag_logic.sv */
// two opposite queues with mailboxes, gray pointer crossing and synchronised flags
`default_nettype none

module bf_flag_logic import bf_pkg::*; #(
    parameter int DEPTH = DEPTH_DEF
) (
    // system
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    // port clocks, sampled as ordinary inputs
    input wire logic PORT_A_CLOCK,
    input wire logic PORT_B_CLOCK,
    // port controls and data
    input wire bf_port_ctrl_t PORT_A_CTRL,
    input wire bf_port_ctrl_t PORT_B_CTRL,
    input wire logic [DATA_W-1:0] PORT_A_DATA_IN,
    input wire logic [DATA_W-1:0] PORT_B_DATA_IN,
    output logic [DATA_W-1:0] PORT_A_DATA_OUT,
    output logic PORT_A_DATA_OE,
    output logic [DATA_W-1:0] PORT_B_DATA_OUT,
    output logic PORT_B_DATA_OE,
    // queue resets and offsets
    input wire logic [1:0] QUEUE_RESET,
    input wire bf_offsets_t OFFSET_PRESET,
    input wire logic OFFSET_WRITE,
    input wire bf_offsets_t OFFSET_VALUE,
    // flags
    output logic PORT_A_IN_READY,
    output logic PORT_A_OUT_READY,
    output logic PORT_A_ALMOST_EMPTY_N,
    output logic PORT_A_ALMOST_FULL_N,
    output logic PORT_B_IN_READY,
    output logic PORT_B_OUT_READY,
    output logic PORT_B_ALMOST_EMPTY_N,
    output logic PORT_B_ALMOST_FULL_N,
    output logic MAIL_ONE_FULL_N,
    output logic MAIL_TWO_FULL_N
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    function automatic logic [CW-1:0] to_gray(input logic [CW-1:0] b);
        to_gray = b ^ (b >> 1);
    endfunction

    function automatic logic [CW-1:0] from_gray(input logic [CW-1:0] g);
        logic [CW-1:0] b;
        b = '0;
        b[CW-1] = g[CW-1];
        for (int i = CW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        from_gray = b;
    endfunction

    // port clock edge detection
    logic a_clk_q, a_clk_d, b_clk_q, b_clk_d;
    logic a_tick, b_tick;

    always_comb begin
        a_clk_d = PORT_A_CLOCK;
        b_clk_d = PORT_B_CLOCK;
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            a_clk_q <= 1'b0;
            b_clk_q <= 1'b0;
        end else if (CLK_EN) begin
            a_clk_q <= a_clk_d;
            b_clk_q <= b_clk_d;
        end
    end

    assign a_tick = CLK_EN & PORT_A_CLOCK & ~a_clk_q;
    assign b_tick = CLK_EN & PORT_B_CLOCK & ~b_clk_q;

    // enable decode
    logic a_act, b_act;
    logic a_qwr, a_qrd, a_mwr, a_mrd;
    logic b_qwr, b_qrd, b_mwr, b_mrd;

    assign a_act = a_tick & ~PORT_A_CTRL.port_select_n & PORT_A_CTRL.port_enable;
    assign a_qwr = a_act & PORT_A_CTRL.port_direction & ~PORT_A_CTRL.port_mail_select;
    assign a_qrd = a_act & ~PORT_A_CTRL.port_direction & ~PORT_A_CTRL.port_mail_select;
    assign a_mwr = a_act & PORT_A_CTRL.port_direction & PORT_A_CTRL.port_mail_select;
    assign a_mrd = a_act & ~PORT_A_CTRL.port_direction & PORT_A_CTRL.port_mail_select;
    assign b_act = b_tick & ~PORT_B_CTRL.port_select_n & PORT_B_CTRL.port_enable;
    assign b_qwr = b_act & ~PORT_B_CTRL.port_direction & ~PORT_B_CTRL.port_mail_select;
    assign b_qrd = b_act & PORT_B_CTRL.port_direction & ~PORT_B_CTRL.port_mail_select;
    assign b_mwr = b_act & ~PORT_B_CTRL.port_direction & PORT_B_CTRL.port_mail_select;
    assign b_mrd = b_act & PORT_B_CTRL.port_direction & PORT_B_CTRL.port_mail_select;

    // per-queue wiring: queue one written on a, read on b; queue two the reverse
    logic [1:0] wr_req, rd_req, w_tick, r_tick;
    logic [DATA_W-1:0] w_data [2];
    logic [OFS_W-1:0] x_pre [2], y_pre [2], x_prog [2], y_prog [2];
    logic [1:0] ir_w, or_w, ae_w, af_w;
    logic [DATA_W-1:0] odata_w [2];

    assign wr_req = {b_qwr, a_qwr};
    assign rd_req = {a_qrd, b_qrd};
    assign w_tick = {b_tick, a_tick};
    assign r_tick = {a_tick, b_tick};
    assign w_data[Q_ONE] = PORT_A_DATA_IN;
    assign w_data[Q_TWO] = PORT_B_DATA_IN;
    assign x_pre[Q_ONE] = OFFSET_PRESET.q1_empty_offset;
    assign y_pre[Q_ONE] = OFFSET_PRESET.q1_full_offset;
    assign x_pre[Q_TWO] = OFFSET_PRESET.q2_empty_offset;
    assign y_pre[Q_TWO] = OFFSET_PRESET.q2_full_offset;
    assign x_prog[Q_ONE] = OFFSET_VALUE.q1_empty_offset;
    assign y_prog[Q_ONE] = OFFSET_VALUE.q1_full_offset;
    assign x_prog[Q_TWO] = OFFSET_VALUE.q2_empty_offset;
    assign y_prog[Q_TWO] = OFFSET_VALUE.q2_full_offset;

    for (genvar g = 0; g < 2; g++) begin : g_queue
        logic [DATA_W-1:0] mem [DEPTH];
        logic [CW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
        logic [CW-1:0] wgray_q, wgray_d, rgray_q, rgray_d;
        logic [CW-1:0] wg_s1_q, wg_s1_d, wg_s2_q, wg_s2_d;
        logic [CW-1:0] rg_s1_q, rg_s1_d, rg_s2_q, rg_s2_d;
        bf_out_state_t ost_q, ost_d;
        logic [DATA_W-1:0] odata_q, odata_d;
        logic in_ready_q, in_ready_d, ae_n_q, ae_n_d, af_n_q, af_n_d;
        logic [OFS_W-1:0] x_q, x_d, y_q, y_d;
        logic [CW-1:0] cnt_w, cnt_r;
        logic wr_ok, avail, load;

        always_comb begin
            // memory counts seen from each side through synchronised pointers
            cnt_w = wptr_q - from_gray(rg_s2_q);
            cnt_r = from_gray(wg_s2_q) - rptr_q;
            avail = (cnt_r != '0);
            wr_ok = wr_req[g] & in_ready_q;
            wptr_d = wptr_q + CW'(wr_ok);
            wgray_d = to_gray(wptr_q);
            rgray_d = to_gray(rptr_q);
            wg_s1_d = r_tick[g] ? wgray_q : wg_s1_q;
            wg_s2_d = r_tick[g] ? wg_s1_q : wg_s2_q;
            rg_s1_d = w_tick[g] ? rgray_q : rg_s1_q;
            rg_s2_d = w_tick[g] ? rg_s1_q : rg_s2_q;
            load = 1'b0;
            ost_d = ost_q;
            if (r_tick[g]) begin
                unique case (ost_q)
                    OUT_EMPTY: begin
                        // fall-through on third reading edge, no read needed
                        load = avail;
                        ost_d = avail ? OUT_HELD : OUT_EMPTY;
                    end
                    OUT_HELD: begin
                        if (rd_req[g]) begin
                            load = avail;
                            ost_d = avail ? OUT_HELD : OUT_EMPTY;
                        end
                    end
                endcase
            end
            rptr_d = rptr_q + CW'(load);
            odata_d = load ? mem[rptr_q[AW-1:0]] : odata_q;
            // full compare uses two-stage read pointer: two writing edges before reuse
            in_ready_d = (cnt_w != CW'(DEPTH));
            ae_n_d = (cnt_r > CW'(x_q));
            af_n_d = (cnt_w <= (CW'(DEPTH - 1) - CW'(y_q)));
            x_d = x_q;
            y_d = y_q;
            if (QUEUE_RESET[g]) begin
                x_d = x_pre[g];
                y_d = y_pre[g];
            end else if (OFFSET_WRITE & a_tick) begin
                x_d = x_prog[g];
                y_d = y_prog[g];
            end
            if (QUEUE_RESET[g]) begin
                wptr_d = '0;
                rptr_d = '0;
                wgray_d = '0;
                rgray_d = '0;
                wg_s1_d = '0;
                wg_s2_d = '0;
                rg_s1_d = '0;
                rg_s2_d = '0;
                ost_d = OUT_EMPTY;
                in_ready_d = 1'b0;
                ae_n_d = 1'b0;
                af_n_d = 1'b1;
            end
        end

        // storage only, no reset needed on the array
        always_ff @(posedge SYS_CLK) begin
            if (CLK_EN && wr_ok && !QUEUE_RESET[g]) begin
                mem[wptr_q[AW-1:0]] <= w_data[g];
            end
        end

        always_ff @(posedge SYS_CLK or negedge RST_N) begin
            if (!RST_N) begin
                wptr_q <= '0;
                rptr_q <= '0;
                wgray_q <= '0;
                rgray_q <= '0;
                wg_s1_q <= '0;
                wg_s2_q <= '0;
                rg_s1_q <= '0;
                rg_s2_q <= '0;
                ost_q <= OUT_EMPTY;
                odata_q <= '0;
                in_ready_q <= 1'b0;
                ae_n_q <= 1'b0;
                af_n_q <= 1'b1;
                x_q <= '0;
                y_q <= '0;
            end else if (CLK_EN) begin
                wptr_q <= wptr_d;
                rptr_q <= rptr_d;
                wgray_q <= wgray_d;
                rgray_q <= rgray_d;
                wg_s1_q <= wg_s1_d;
                wg_s2_q <= wg_s2_d;
                rg_s1_q <= rg_s1_d;
                rg_s2_q <= rg_s2_d;
                ost_q <= ost_d;
                odata_q <= odata_d;
                in_ready_q <= in_ready_d;
                ae_n_q <= ae_n_d;
                af_n_q <= af_n_d;
                x_q <= x_d;
                y_q <= y_d;
            end
        end

        assign ir_w[g] = in_ready_q;
        assign or_w[g] = (ost_q == OUT_HELD);
        assign ae_w[g] = ae_n_q;
        assign af_w[g] = af_n_q;
        assign odata_w[g] = odata_q;
    end

    // mailboxes and data outputs
    logic [DATA_W-1:0] mail1_q, mail1_d, mail2_q, mail2_d;
    logic mf1_n_q, mf1_n_d, mf2_n_q, mf2_n_d;
    logic [DATA_W-1:0] a_out_q, a_out_d, b_out_q, b_out_d;
    logic a_oe_q, a_oe_d, b_oe_q, b_oe_d;

    always_comb begin
        mail1_d = mail1_q;
        mail2_d = mail2_q;
        mf1_n_d = mf1_n_q;
        mf2_n_d = mf2_n_q;
        // write to an empty mailbox outranks a same-cycle read; a write while full is dropped
        if (a_mwr && mf1_n_q) begin
            mail1_d = PORT_A_DATA_IN;
            mf1_n_d = 1'b0;
        end else if (b_mrd) begin
            mf1_n_d = MAIL_EMPTY;
        end
        if (b_mwr && mf2_n_q) begin
            mail2_d = PORT_B_DATA_IN;
            mf2_n_d = 1'b0;
        end else if (a_mrd) begin
            mf2_n_d = MAIL_EMPTY;
        end
        a_out_d = PORT_A_CTRL.port_mail_select ? mail2_q : odata_w[Q_TWO];
        b_out_d = PORT_B_CTRL.port_mail_select ? mail1_q : odata_w[Q_ONE];
        // enables lag the selects by one system clock
        a_oe_d = ~PORT_A_CTRL.port_select_n & ~PORT_A_CTRL.port_direction;
        b_oe_d = ~PORT_B_CTRL.port_select_n & PORT_B_CTRL.port_direction;
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mail1_q <= '0;
            mail2_q <= '0;
            mf1_n_q <= MAIL_EMPTY;
            mf2_n_q <= MAIL_EMPTY;
            a_out_q <= '0;
            b_out_q <= '0;
            a_oe_q <= 1'b0;
            b_oe_q <= 1'b0;
        end else if (CLK_EN) begin
            mail1_q <= mail1_d;
            mail2_q <= mail2_d;
            mf1_n_q <= mf1_n_d;
            mf2_n_q <= mf2_n_d;
            a_out_q <= a_out_d;
            b_out_q <= b_out_d;
            a_oe_q <= a_oe_d;
            b_oe_q <= b_oe_d;
        end
    end

    assign PORT_A_DATA_OUT = a_out_q;
    assign PORT_A_DATA_OE = a_oe_q;
    assign PORT_B_DATA_OUT = b_out_q;
    assign PORT_B_DATA_OE = b_oe_q;
    assign MAIL_ONE_FULL_N = mf1_n_q;
    assign MAIL_TWO_FULL_N = mf2_n_q;
    assign PORT_A_IN_READY = ir_w[Q_ONE];
    assign PORT_A_ALMOST_FULL_N = af_w[Q_ONE];
    assign PORT_B_OUT_READY = or_w[Q_ONE];
    assign PORT_B_ALMOST_EMPTY_N = ae_w[Q_ONE];
    assign PORT_B_IN_READY = ir_w[Q_TWO];
    assign PORT_B_ALMOST_FULL_N = af_w[Q_TWO];
    assign PORT_A_OUT_READY = or_w[Q_TWO];
    assign PORT_A_ALMOST_EMPTY_N = ae_w[Q_TWO];

endmodule // bf_flag_logic

`default_nettype wire

/* verif/bf_flag_logic_chk.sv */
// concurrent checks on the port pins of the flag logic
`default_nettype none

module bf_flag_logic_chk import bf_pkg::*; (
    // system
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    // port side
    input wire logic PORT_A_CLOCK,
    input wire logic PORT_B_CLOCK,
    input wire bf_port_ctrl_t PORT_A_CTRL,
    input wire bf_port_ctrl_t PORT_B_CTRL,
    input wire logic [1:0] QUEUE_RESET,
    // outputs watched
    input wire logic PORT_A_DATA_OE,
    input wire logic PORT_B_DATA_OE,
    input wire logic PORT_A_IN_READY,
    input wire logic PORT_A_ALMOST_FULL_N,
    input wire logic PORT_B_OUT_READY,
    input wire logic PORT_B_ALMOST_EMPTY_N,
    input wire logic MAIL_ONE_FULL_N,
    input wire logic MAIL_TWO_FULL_N
);
    timeunit 1ns;
    timeprecision 100ps;
    logic a_q, b_q, ta, tb;
    logic [1:0] ca_q, ca_d, cb_q, cb_d;

    // tick counts saturate at 3: only "two or more since" matters
    always_comb begin
        ta = PORT_A_CLOCK && !a_q;
        tb = PORT_B_CLOCK && !b_q;
        ca_d = (tb && PORT_B_CTRL == 4'h6 && PORT_B_OUT_READY) ? 2'h0 : ca_q + {1'b0, ta && ca_q != 2'h3};
        cb_d = (ta && PORT_A_CTRL == 4'h6 && PORT_A_IN_READY) ? 2'h0 : cb_q + {1'b0, tb && cb_q != 2'h3};
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            ca_q <= 2'h3;
            cb_q <= 2'h3;
        end else if (CLK_EN) begin
            // frozen with the design so both see the same port ticks
            a_q <= PORT_A_CLOCK;
            b_q <= PORT_B_CLOCK;
            ca_q <= ca_d;
            cb_q <= cb_d;
        end
    end

    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N || !CLK_EN);

    AST_OE_ON: assert property (
        !PORT_B_CTRL.port_select_n && PORT_B_CTRL.port_direction |=> PORT_B_DATA_OE)
        else $error("port b data not driven on selected read");
    AST_OE_OFF: assert property (
        PORT_B_CTRL.port_select_n || !PORT_B_CTRL.port_direction |=> !PORT_B_DATA_OE)
        else $error("port b data driven while deselected or writing");
    AST_OE_A_ON: assert property (
        !PORT_A_CTRL.port_select_n && !PORT_A_CTRL.port_direction |=> PORT_A_DATA_OE)
        else $error("port a data not driven on selected read");
    AST_MAIL1_CLR: assert property (
        tb && PORT_B_CTRL == 4'h7 && !(ta && PORT_A_CTRL == 4'h7) |=> MAIL_ONE_FULL_N)
        else $error("mail one flag not set by read");
    AST_MAIL2_SET: assert property (
        tb && PORT_B_CTRL == 4'h3 && MAIL_TWO_FULL_N |=> !MAIL_TWO_FULL_N)
        else $error("mail two flag not cleared by write");
    AST_MAIL2_HOLD: assert property (
        !MAIL_TWO_FULL_N && !(ta && PORT_A_CTRL == 4'h3) && QUEUE_RESET == 2'h0 |=> !MAIL_TWO_FULL_N)
        else $error("mail two flag left low state without read");
    AST_IR_RISE: assert property (
        $rose(PORT_A_IN_READY) |-> ca_q >= 2'h2)
        else $error("input ready rose before two writer ticks");
    AST_AE_RISE: assert property (
        $rose(PORT_B_ALMOST_EMPTY_N) |-> cb_q >= 2'h2)
        else $error("almost empty rose before two reader ticks");
    AST_AF_RISE: assert property (
        $rose(PORT_A_ALMOST_FULL_N) && QUEUE_RESET == 2'h0 |-> ca_q >= 2'h2)
        else $error("almost full rose before two writer ticks");
    AST_AF_IR: assert property (
        !PORT_A_IN_READY && $past(RST_N, 2) && QUEUE_RESET == 2'h0 && !$past(QUEUE_RESET[0])
        && !$past(QUEUE_RESET[0], 2) |-> !PORT_A_ALMOST_FULL_N)
        else $error("full queue without almost full");
    AST_QRST: assert property (
        QUEUE_RESET[0] |=> !PORT_A_IN_READY && !PORT_B_OUT_READY && PORT_A_ALMOST_FULL_N && !PORT_B_ALMOST_EMPTY_N)
        else $error("queue one flags wrong during reset");
endmodule // bf_flag_logic_chk

`default_nettype wire

/* verif/bf_port_bfm.sv */
// port master model: free-running port clock and held requests
`default_nettype none

module bf_port_bfm import bf_pkg::*; #(
    parameter int HALF = 2,
    parameter logic RD = 1'b1
) (
    // system clock
    input wire logic clk,
    // port pins
    output logic pclk,
    output bf_port_ctrl_t ctrl,
    output logic [DATA_W-1:0] dout,
    input wire logic [DATA_W-1:0] din
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = 0;
    initial begin
        pclk = 1'b0;
        ctrl = 4'h8;
        dout = '0;
    end
    // half period of two or more system cycles keeps every level visible
    always @(posedge clk) begin
        #2;
        cnt = (cnt + 1) % HALF;
        pclk = pclk ^ (cnt == 0);
    end
    // held from the low phase through the sampling edge; released data is inverted
    task automatic op(input bf_port_ctrl_t c, input logic [DATA_W-1:0] d);
        @(negedge pclk);
        ctrl = c;
        dout = d;
        @(posedge pclk);
        @(posedge clk);
        #2;
        ctrl = 4'h8;
        dout = ~d;
        repeat (2) @(posedge clk);
        #2;
    endtask
    // enable low: output is shown, nothing is taken
    task automatic look(input logic m, output logic [DATA_W-1:0] q);
        ctrl = {1'b0, RD, 1'b0, m};
        repeat (3) @(posedge clk);
        #2;
        q = din;
        ctrl = 4'h8;
    endtask
endmodule // bf_port_bfm

`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the bidirectional queue flag logic
`default_nettype none

module testbench import bf_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int D = 256;
    localparam int XO = 2;
    localparam int YO = 3;
    logic SYS_CLK, RST_N, CLK_EN, PORT_A_CLOCK, PORT_B_CLOCK, OFFSET_WRITE;
    logic PORT_A_IN_READY, PORT_A_OUT_READY, PORT_A_ALMOST_EMPTY_N, PORT_A_ALMOST_FULL_N;
    logic PORT_B_IN_READY, PORT_B_OUT_READY, PORT_B_ALMOST_EMPTY_N, PORT_B_ALMOST_FULL_N;
    logic MAIL_ONE_FULL_N, MAIL_TWO_FULL_N;
    logic [1:0] QUEUE_RESET;
    bf_port_ctrl_t PORT_A_CTRL, PORT_B_CTRL;
    bf_offsets_t OFFSET_PRESET, OFFSET_VALUE;
    logic [DATA_W-1:0] PORT_A_DATA_IN, PORT_B_DATA_IN, PORT_A_DATA_OUT, PORT_B_DATA_OUT;
    int err_count = 0;
    int samples_checked = 0;
    int nw = 0;

    bf_flag_logic #(.DEPTH(D)) dut (
        .SYS_CLK, .RST_N, .CLK_EN, .PORT_A_CLOCK, .PORT_B_CLOCK, .PORT_A_CTRL, .PORT_B_CTRL,
        .PORT_A_DATA_IN, .PORT_B_DATA_IN, .PORT_A_DATA_OUT, .PORT_A_DATA_OE(), .PORT_B_DATA_OUT,
        .PORT_B_DATA_OE(), .QUEUE_RESET, .OFFSET_PRESET, .OFFSET_WRITE, .OFFSET_VALUE,
        .PORT_A_IN_READY, .PORT_A_OUT_READY, .PORT_A_ALMOST_EMPTY_N, .PORT_A_ALMOST_FULL_N,
        .PORT_B_IN_READY, .PORT_B_OUT_READY, .PORT_B_ALMOST_EMPTY_N, .PORT_B_ALMOST_FULL_N,
        .MAIL_ONE_FULL_N, .MAIL_TWO_FULL_N);
    bf_port_bfm #(.HALF(2), .RD(1'b0)) pa (.clk(SYS_CLK), .pclk(PORT_A_CLOCK), .ctrl(PORT_A_CTRL),
        .dout(PORT_A_DATA_IN), .din(PORT_A_DATA_OUT));
    bf_port_bfm #(.HALF(3), .RD(1'b1)) pb (.clk(SYS_CLK), .pclk(PORT_B_CLOCK), .ctrl(PORT_B_CTRL),
        .dout(PORT_B_DATA_IN), .din(PORT_B_DATA_OUT));

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge SYS_CLK);
        #2;
    endtask
    // queue-one writes from port a, then long enough for both sides to settle
    task automatic put(input int n);
        repeat (n) begin
            nw++;
            pa.op(4'h6, DATA_W'(nw));
        end
        tick(30);
    endtask
    task automatic t_mail();
        logic [DATA_W-1:0] q;
        pb.op(4'h1, 36'h123456789);
        chk(MAIL_TWO_FULL_N, 1'b1);
        pb.op(4'h3, 36'h123456789);
        pb.op(4'h3, 36'h0F0F0F0F0);
        chk(MAIL_TWO_FULL_N, 1'b0);
        pa.look(1'b1, q);
        chk(q, 36'h123456789);
        pa.op(4'h3, '0);
        chk(MAIL_TWO_FULL_N, 1'b1);
        pa.op(4'h7, 36'hABCDEF012);
        chk(MAIL_ONE_FULL_N, 1'b0);
        pb.look(1'b1, q);
        chk(q, 36'hABCDEF012);
        pb.op(4'h7, '0);
        chk(MAIL_ONE_FULL_N, 1'b1);
    endtask
    task automatic t_q1();
        logic [DATA_W-1:0] q;
        QUEUE_RESET = 2'h3;
        tick(4);
        QUEUE_RESET = 2'h0;
        tick(4);
        chk(PORT_B_OUT_READY, 1'b0);
        chk(PORT_A_IN_READY, 1'b1);
        put(1);
        chk(PORT_B_OUT_READY, 1'b1);
        pb.look(1'b0, q);
        chk(q, 36'h1);
        put(XO);
        chk(PORT_B_ALMOST_EMPTY_N, 1'b0);
        put(1);
        chk(PORT_B_ALMOST_EMPTY_N, 1'b1);
        put(D - YO - XO - 2);
        chk(PORT_A_ALMOST_FULL_N, 1'b1);
        put(1);
        chk(PORT_A_ALMOST_FULL_N, 1'b0);
        put(YO);
        chk(PORT_A_IN_READY, 1'b0);
        put(1);
        chk(PORT_A_IN_READY, 1'b0);
        pb.op(4'h6, '0);
        tick(30);
        chk(PORT_A_IN_READY, 1'b1);
        pb.look(1'b0, q);
        chk(q, 36'h2);
        repeat (YO) pb.op(4'h6, '0);
        tick(30);
        chk(PORT_A_ALMOST_FULL_N, 1'b1);
        OFFSET_VALUE = '{OFS_W'(D - 1 - YO), OFS_W'(YO), '0, '0};
        OFFSET_WRITE = 1'b1;
        tick(12);
        OFFSET_WRITE = 1'b0;
        tick(30);
        chk(PORT_B_ALMOST_EMPTY_N, 1'b0);
    endtask
    task automatic t_q2();
        logic [DATA_W-1:0] q;
        pb.op(4'h2, 36'hCAFE0);
        tick(30);
        chk(PORT_A_OUT_READY, 1'b1);
        chk(PORT_A_ALMOST_EMPTY_N, 1'b0);
        chk(PORT_B_IN_READY, 1'b1);
        chk(PORT_B_ALMOST_FULL_N, 1'b1);
        pa.look(1'b0, q);
        chk(q, 36'hCAFE0);
    endtask
    // a read while the clock enable is low must be lost: fifth word stays in the output register
    task automatic t_hold();
        logic [DATA_W-1:0] q;
        CLK_EN = 1'b0;
        pb.op(4'h6, '0);
        tick(30);
        CLK_EN = 1'b1;
        tick(30);
        pb.look(1'b0, q);
        chk(q, 36'h5);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        SYS_CLK = 1'b0;
        forever #12.5 SYS_CLK = ~SYS_CLK;
    end
    // the run needs well under a tenth of this
    initial begin
        repeat (40000) @(posedge SYS_CLK);
        err_count++;
        test_done();
    end
    initial begin
        RST_N = 1'b0;
        CLK_EN = 1'b1;
        QUEUE_RESET = 2'h0;
        OFFSET_WRITE = 1'b0;
        OFFSET_PRESET = '{OFS_W'(XO), OFS_W'(YO), OFS_W'(XO), OFS_W'(YO)};
        OFFSET_VALUE = '0;
        tick(16);
        RST_N = 1'b1;
        tick(4);
        t_mail();
        t_q1();
        t_hold();
        t_q2();
        test_done();
    end
endmodule // testbench

bind bf_flag_logic bf_flag_logic_chk chk (.SYS_CLK, .RST_N, .CLK_EN, .PORT_A_CLOCK, .PORT_B_CLOCK, .PORT_A_CTRL,
    .PORT_B_CTRL, .QUEUE_RESET, .PORT_A_DATA_OE, .PORT_B_DATA_OE, .PORT_A_IN_READY, .PORT_A_ALMOST_FULL_N,
    .PORT_B_OUT_READY, .PORT_B_ALMOST_EMPTY_N, .MAIL_ONE_FULL_N, .MAIL_TWO_FULL_N);

`default_nettype wire
